// ### ssw_device.sv
// Supply supervisor: timed reset, watchdog and power-fail flag
// Behaviour
// - Supply low asserts both resets immediately
// - Resets asserted from power-up while supply low
// - Resets release after 200ms above threshold
// - Supply low keeps clearing the pulse timer
// - Reset pulse never shorter than 140ms
// - Pushbutton low resets, same timed release
// - Host holds pushbutton low 500ns/150ns minimum
// - No kick edge in 1.6s drives timeout low
// - Reset clears and stops the watchdog
// - Watchdog starts from zero on reset release
// - Kick pulses 100ns/50ns wide are recognised
// - Disable variant: floating kick stops watchdog
// - Floating kick allowed only when timeout idle
// - Supply low drives timeout low at once
// - Timeout should feed pushbutton, not reset
// - Aux below 1.25V flags fail, 10mV hysteresis
// - Power-fail output may feed the pushbutton
// - Every kick edge clears the watchdog
// - Timeout holds until kick, even through supply low
`timescale 1ns/10ps
module ssw_device #(
  parameter int unsigned TICK_CYC = ssw_pkg::TICK_CYC, // Cycles per 1 ms tick
  parameter bit HAS_DISABLE = 1'b1 // Variant with floating-kick disable
) (
  input wire logic clock_in,
  input wire logic srst_in,
  input wire logic supply_low_in, // Supply below threshold, async
  input wire logic [ssw_pkg::AUX_MV_W-1:0] aux_monitor_in, // Aux level in mV
  ssw_link_if.dev link
);
  // Device state, apart from the pushbutton and kick synchronisers
  typedef struct packed {
    ssw_pkg::ssw_state_t state;
    logic [ssw_pkg::PRE_W-1:0] pre; // Prescaler
    logic [ssw_pkg::TICK_W-1:0] rst_ticks; // Reset pulse timer
    logic [ssw_pkg::TICK_W-1:0] wd_ticks; // Watchdog timer
    logic wd_expired; // Timeout latched
    logic aux_fail; // Comparator output
    logic sup_a; // Supply sync stage one
    logic sup_b; // Supply sync stage two
    logic float_a; // Float sync stage one
    logic float_b; // Float sync stage two
  } ssw_dev_t;
  ssw_dev_t st;
  ssw_dev_t next_st;
  logic pb_level; // Synchronised pushbutton
  logic kick_edge; // One-cycle kick clear
  logic tick; // Prescaler terminal count
  logic trigger; // Any reset cause present
  logic wd_off; // Watchdog disabled by float

  // Pushbutton level through two flops
  ssw_sync u_pb_sync (
    .clock_in(clock_in),
    .srst_in(srst_in),
    .async_in(link.pushbutton_reset_n),
    .init_in(1'b1),
    .level_out(pb_level),
    .edge_out()
  );
  // Kick synchronised, either edge a pulse
  ssw_sync u_kick_sync (
    .clock_in(clock_in),
    .srst_in(srst_in),
    .async_in(link.kick_input),
    .init_in(1'b0),
    .level_out(),
    .edge_out(kick_edge)
  );

  // Last prescaler count; declared before use so strict readers accept it
  localparam logic [ssw_pkg::PRE_W-1:0] PRE_W_LAST = ssw_pkg::PRE_W'(TICK_CYC - 1);
  assign tick = (st.pre == PRE_W_LAST);
  // Floating line only disables in the variant, never once expired
  assign wd_off = HAS_DISABLE && st.float_b && !st.wd_expired;
  assign trigger = st.sup_b || !pb_level;

  // Next-state logic
  always_comb begin
    next_st = st;
    next_st.sup_a = supply_low_in;
    next_st.sup_b = st.sup_a;
    next_st.float_a = link.kick_oe_n;
    next_st.float_b = st.float_a;
    // Free-running prescaler
    next_st.pre = tick ? '0 : st.pre + 1'b1;
    unique case (st.state)
      ssw_pkg::SSW_HOLD: begin
        // Timer held at zero while a cause stands
        next_st.rst_ticks = '0;
        if (!trigger) begin
          next_st.state = ssw_pkg::SSW_PULSE;
        end
      end
      ssw_pkg::SSW_PULSE: begin
        if (trigger) begin
          next_st.state = ssw_pkg::SSW_HOLD;
          next_st.rst_ticks = '0;
        end else if (st.rst_ticks >= ssw_pkg::TICK_W'(ssw_pkg::RST_TICKS)) begin
          // 200 ticks also covers the 140 least
          next_st.state = ssw_pkg::SSW_RUN;
        end else if (tick) begin
          next_st.rst_ticks = st.rst_ticks + 1'b1;
        end
      end
      ssw_pkg::SSW_RUN: begin
        if (trigger) begin
          next_st.state = ssw_pkg::SSW_HOLD;
        end
      end
      default: begin
        next_st.state = ssw_pkg::SSW_HOLD;
      end
    endcase
    // Watchdog counts only while running
    if (st.state != ssw_pkg::SSW_RUN || trigger) begin
      next_st.wd_ticks = '0;
    end else if (kick_edge) begin
      next_st.wd_ticks = '0;
      next_st.wd_expired = 1'b0;
    end else if (wd_off) begin
      next_st.wd_ticks = '0;
    end else if (st.wd_ticks >= ssw_pkg::TICK_W'(ssw_pkg::WDOG_TICKS)) begin
      next_st.wd_expired = 1'b1;
    end else if (tick) begin
      next_st.wd_ticks = st.wd_ticks + 1'b1;
    end
    // Kick edge during reset still clears a stale timeout
    if (kick_edge) begin
      next_st.wd_expired = 1'b0;
    end
    // Comparator with hysteresis band above the reference
    if (aux_monitor_in < ssw_pkg::AUX_MV_W'(ssw_pkg::AUX_REF_MV)) begin
      next_st.aux_fail = 1'b1;
    end else if (aux_monitor_in >=
                 ssw_pkg::AUX_MV_W'(ssw_pkg::AUX_REF_MV + ssw_pkg::AUX_HYST_MV)) begin
      next_st.aux_fail = 1'b0;
    end
  end

  // State register, asserted-reset state after srst
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      st <= '{state: ssw_pkg::SSW_HOLD, pre: '0, rst_ticks: '0, wd_ticks: '0,
              wd_expired: 1'b0, aux_fail: 1'b0, sup_a: 1'b1, sup_b: 1'b1,
              float_a: 1'b0, float_b: 1'b0};
    end else begin
      st <= next_st;
    end
  end

  // Outputs: reset asserted whenever the state is not run
  assign link.reset_n = (st.state == ssw_pkg::SSW_RUN);
  assign link.reset = (st.state != ssw_pkg::SSW_RUN);
  // Supply low drops timeout at once; released with supply unless wd_expired holds it
  assign link.kick_timeout_n = !(st.wd_expired || st.sup_b);
  assign link.aux_fail_n = !st.aux_fail;
endmodule : ssw_device

// ### ssw_host.sv
// Processor end: kicks the watchdog and drives the pushbutton
`timescale 1ns/10ps
module ssw_host (
  input wire logic clock_in,
  input wire logic srst_in,
  input wire logic kick_req_in, // Pulse: toggle the kick line
  input wire logic float_req_in, // Level: release the kick line
  input wire logic button_req_in, // Pulse: press the pushbutton
  input wire logic route_timeout_in, // Feed timeout into pushbutton
  input wire logic route_fail_in, // Feed power-fail into pushbutton
  output logic in_reset_out, // Processor held in reset
  output logic timeout_seen_out, // Timeout line low
  output logic fail_seen_out, // Power-fail line low
  ssw_link_if.host link
);
  // Host state
  typedef struct packed {
    logic kick; // Kick level
    logic [7:0] kick_hold; // Cycles the level must stand
    logic [7:0] pb_hold; // Cycles button stays pressed
    logic rst_a;
    logic rst_b;
    logic wdo_a;
    logic wdo_b;
    logic pf_a;
    logic pf_b;
  } ssw_host_t;
  ssw_host_t st;
  ssw_host_t next_st;

  // Next state
  always_comb begin
    next_st = st;
    next_st.rst_a = link.reset;
    next_st.rst_b = st.rst_a;
    next_st.wdo_a = link.kick_timeout_n;
    next_st.wdo_b = st.wdo_a;
    next_st.pf_a = link.aux_fail_n;
    next_st.pf_b = st.pf_a;
    // Each level held wide enough to be seen
    if (st.kick_hold != 8'h00) begin
      next_st.kick_hold = st.kick_hold - 8'h01;
    end else if (kick_req_in) begin
      next_st.kick = !st.kick;
      next_st.kick_hold = 8'(ssw_pkg::KICK_HOLD_CYC);
    end
    // Button press held its least width
    if (button_req_in || (route_timeout_in && !st.wdo_b)
        || (route_fail_in && !st.pf_b)) begin
      next_st.pb_hold = 8'(ssw_pkg::PB_HOLD_CYC);
    end else if (st.pb_hold != 8'h00) begin
      next_st.pb_hold = st.pb_hold - 8'h01;
    end
  end

  // Registers
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      st <= '{kick: 1'b0, kick_hold: 8'h00, pb_hold: 8'h00, rst_a: 1'b1, rst_b: 1'b1,
              wdo_a: 1'b1, wdo_b: 1'b1, pf_a: 1'b1, pf_b: 1'b1};
    end else begin
      st <= next_st;
    end
  end

  assign link.kick_input = st.kick;
  // Float only while timeout is idle
  assign link.kick_oe_n = float_req_in && st.wdo_b;
  assign link.pushbutton_reset_n = (st.pb_hold == 8'h00);
  assign in_reset_out = st.rst_b;
  assign timeout_seen_out = !st.wdo_b;
  assign fail_seen_out = !st.pf_b;
endmodule : ssw_host

// ### ssw_link_assertions.sv
// Concurrent checks on the link between supervisor and processor
`timescale 1ns/10ps
module ssw_link_assertions #(
  parameter int unsigned TICK_CYC = 10 // Cycles per tick
) (
  input wire logic clock_in,
  input wire logic srst_in,
  input wire logic reset_n,
  input wire logic reset,
  input wire logic kick_timeout_n,
  input wire logic aux_fail_n,
  input wire logic pushbutton_reset_n,
  input wire logic kick_input,
  input wire logic kick_oe_n
);
  localparam int unsigned P_MIN = 140 * TICK_CYC; // Least pulse
  localparam int unsigned P_MAX = 200 * TICK_CYC + 8; // Pulse plus sync lag
  localparam int unsigned WD_MIN = 1599 * TICK_CYC; // First tick may be partial
  localparam int unsigned WD_DUE = 1600 * TICK_CYC + 8; // Device clears lag ours
  int unsigned held; // Cycles with reset asserted
  int unsigned quiet; // Cycles in reset with no cause seen
  int unsigned idle; // Cycles since a watchdog clear
  logic kick_q; // Last kick level
  default clocking @(posedge clock_in); endclocking
  default disable iff (srst_in);
  // Helper counters; supply is not visible, but it drags the timeout low
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      held <= 0;
      quiet <= 0;
      idle <= 0;
    end else begin
      held <= reset_n ? 0 : held + 1;
      quiet <= (reset_n || !pushbutton_reset_n || !kick_timeout_n) ? 0 : quiet + 1;
      idle <= (!reset_n || kick_oe_n || kick_input != kick_q) ? 0 : idle + 1;
    end
    kick_q <= kick_input;
  end
  a_reset_pair: assert property (reset == !reset_n)
    else $error("reset outputs not complementary");
  a_button_holds: assert property (!pushbutton_reset_n [*4] |-> !reset_n)
    else $error("button low without reset");
  a_pulse_min: assert property ($rose(reset_n) |-> held >= P_MIN)
    else $error("reset pulse too short");
  a_release_due: assert property (!reset_n |-> quiet <= P_MAX)
    else $error("reset held too long");
  a_timeout_due: assert property (reset_n && idle == WD_DUE |-> !kick_timeout_n)
    else $error("watchdog did not expire");
  a_no_early_tmo: assert property ($fell(kick_timeout_n) |->
    (idle >= WD_MIN) or (##[0:3] !reset_n))
    else $error("timeout low too early");
  a_kick_clears: assert property ($changed(kick_input) && !kick_oe_n |->
    ##[1:5] kick_timeout_n)
    else $error("kick edge left timeout low");
  a_float_idle: assert property ($rose(kick_oe_n) |-> kick_timeout_n)
    else $error("kick floated during timeout");
  c_aux_fail: cover property (!aux_fail_n);
endmodule : ssw_link_assertions

// ### ssw_link_if.sv
// Interface joining the supervisor device and the processor side
`timescale 1ns/10ps
interface ssw_link_if;
  logic reset_n; // Active-low reset to processor
  logic reset; // Active-high reset to processor
  logic kick_timeout_n; // Watchdog timeout, active low
  logic aux_fail_n; // Power-fail flag, active low
  logic pushbutton_reset_n; // Manual reset, active low
  logic kick_input; // Watchdog kick level
  logic kick_oe_n; // Low while the kick line is driven
  modport dev (
    output reset_n, reset, kick_timeout_n, aux_fail_n,
    input pushbutton_reset_n, kick_input, kick_oe_n
  );
  modport host (
    input reset_n, reset, kick_timeout_n, aux_fail_n,
    output pushbutton_reset_n, kick_input, kick_oe_n
  );
endinterface : ssw_link_if

// ### ssw_pkg.sv
// Shared constants and types for the supply supervisor and watchdog
package ssw_pkg;
  // Internal time base rate and period
  localparam int unsigned CLK_HZ = 100000000;
  localparam int unsigned CLK_NS = 10;
  // Reset pulse widths, nominal and least, in milliseconds
  localparam int unsigned RST_PULSE_MS = 200;
  localparam int unsigned RST_MIN_MS = 140;
  // Watchdog timeout in milliseconds
  localparam int unsigned WDOG_MS = 1600;
  // Least pushbutton and kick widths in nanoseconds
  localparam int unsigned PB_MIN_NS_3V = 500;
  localparam int unsigned PB_MIN_NS_5V = 150;
  localparam int unsigned KICK_MIN_NS_LO = 100;
  localparam int unsigned KICK_MIN_NS_HI = 50;
  // Prescaler tick of 1 ms, counted in clock cycles
  localparam int unsigned TICK_US = 1000;
  localparam int unsigned TICK_CYC = TICK_US * (CLK_HZ / 1000000);
  // Counts of ticks derived from the times
  localparam int unsigned RST_TICKS = RST_PULSE_MS * 1000 / TICK_US;
  localparam int unsigned RST_MIN_TICKS = (RST_MIN_MS * 1000 + TICK_US - 1) / TICK_US;
  localparam int unsigned WDOG_TICKS = WDOG_MS * 1000 / TICK_US;
  // Cycles that a host holds its pulses, least width rounded up
  localparam int unsigned PB_HOLD_CYC = (PB_MIN_NS_3V + CLK_NS - 1) / CLK_NS;
  localparam int unsigned KICK_HOLD_CYC = (KICK_MIN_NS_LO + CLK_NS - 1) / CLK_NS;
  // Comparator reference and hysteresis in millivolts
  localparam int unsigned AUX_REF_MV = 1250;
  localparam int unsigned AUX_HYST_MV = 10;
  localparam int unsigned AUX_MV_W = 16;
  // Counter widths
  localparam int unsigned PRE_W = 32;
  localparam int unsigned TICK_W = 16;
  // Reset sequencer states, one-hot
  typedef enum logic [2:0] {
    SSW_HOLD = 3'b001,
    SSW_PULSE = 3'b010,
    SSW_RUN = 3'b100
  } ssw_state_t;
endpackage : ssw_pkg

// ### ssw_sync.sv
// Two-flop synchroniser with edge detection behind it
`timescale 1ns/10ps
module ssw_sync (
  input wire logic clock_in,
  input wire logic srst_in,
  input wire logic async_in,
  input wire logic init_in,
  output logic level_out,
  output logic edge_out
);
  // Stage one, stage two, and the delayed copy for edges
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
  } ssw_sync_t;
  ssw_sync_t st;
  ssw_sync_t next_st;

  // Stage one feeds only stage two
  always_comb begin
    next_st.s1 = async_in;
    next_st.s2 = st.s1;
    next_st.s3 = st.s2;
  end

  // Reset loads the idle level so no false edge appears
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      st <= {3{init_in}};
    end else begin
      st <= next_st;
    end
  end

  assign level_out = st.s2;
  // Both polarities give one pulse
  assign edge_out = st.s2 ^ st.s3;
endmodule : ssw_sync

// ### tb_top.sv
// Self-checking bench for the supervisor and its processor end
`timescale 1ns/10ps
module tb_top;
  localparam int T = 10; // Short tick keeps the run brief
  localparam int PMIN = 199 * T; // Earliest release
  localparam int PMAX = 200 * T + 8; // Latest release
  logic clock_in = 1'b0;
  logic srst_in = 1'b1;
  logic supply_low = 1'b1; // Start below threshold
  logic [ssw_pkg::AUX_MV_W-1:0] aux_mv = 16'h07d0;
  logic kick_req = 1'b0;
  logic float_req = 1'b0;
  logic button_req = 1'b0;
  logic route_tmo = 1'b0;
  logic route_fail = 1'b0;
  logic in_reset;
  logic tmo_seen;
  logic fail_seen;
  int miscompares = 0;
  int comparisons = 0;
  int n;
  // Comparator steps: 1250, 1249, 1259, 1260 mV
  logic [ssw_pkg::AUX_MV_W-1:0] aux_tab [4] = '{16'h04e2, 16'h04e1, 16'h04eb, 16'h04ec};
  logic fail_tab [4] = '{1'b1, 1'b0, 1'b0, 1'b1};
  ssw_link_if lk();
  ssw_device #(.TICK_CYC(T)) u_ssw_device (.clock_in(clock_in), .srst_in(srst_in),
    .supply_low_in(supply_low), .aux_monitor_in(aux_mv), .link(lk));
  ssw_host u_ssw_host (.clock_in(clock_in), .srst_in(srst_in), .kick_req_in(kick_req),
    .float_req_in(float_req), .button_req_in(button_req), .route_timeout_in(route_tmo),
    .route_fail_in(route_fail), .in_reset_out(in_reset), .timeout_seen_out(tmo_seen),
    .fail_seen_out(fail_seen), .link(lk));
  ssw_link_assertions #(.TICK_CYC(T)) u_ssw_link_assertions (.clock_in(clock_in),
    .srst_in(srst_in), .reset_n(lk.reset_n), .reset(lk.reset),
    .kick_timeout_n(lk.kick_timeout_n), .aux_fail_n(lk.aux_fail_n),
    .pushbutton_reset_n(lk.pushbutton_reset_n), .kick_input(lk.kick_input),
    .kick_oe_n(lk.kick_oe_n));
  // Free-running 100 MHz clock
  always #5 clock_in = ~clock_in;
  task automatic cyc(input int c);
    repeat (c) @(negedge clock_in);
  endtask : cyc
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask : chk
  task automatic test_done;
    $display("miscompares %0d comparisons %0d", miscompares, comparisons);
    if (miscompares == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : test_done
  // Bounded wait on reset_n (sel 0) or the timeout line (sel 1)
  task automatic wait_sig(input int sel, input logic val, input int maxc, output int c);
    c = 0;
    while (((sel == 0) ? lk.reset_n : lk.kick_timeout_n) !== val) begin
      if (c >= maxc) begin
        miscompares++;
        test_done();
      end
      cyc(1);
      c++;
    end
  endtask : wait_sig
  // One kick toggle, then the host's spacing
  task automatic kick;
    kick_req = 1'b1;
    cyc(1);
    kick_req = 1'b0;
    cyc(12);
  endtask : kick
  // Main sequence
  initial begin
    cyc(4);
    srst_in = 1'b0;
    cyc(50);
    chk(lk.reset_n, 1'b0);
    chk(in_reset, 1'b1);
    supply_low = 1'b0;
    wait_sig(0, 1'b1, PMAX + 4, n);
    chk(n >= PMIN, 1'b1);
    supply_low = 1'b1;
    cyc(4);
    chk({lk.reset_n, lk.reset, lk.kick_timeout_n}, 3'h2);
    supply_low = 1'b0;
    cyc(4);
    chk(lk.kick_timeout_n, 1'b1);
    cyc(1000);
    supply_low = 1'b1;
    cyc(3);
    supply_low = 1'b0;
    wait_sig(0, 1'b1, PMAX + 4, n);
    chk(n >= PMIN, 1'b1);
    button_req = 1'b1;
    cyc(1);
    button_req = 1'b0;
    cyc(10);
    chk(lk.reset_n, 1'b0);
    wait_sig(0, 1'b1, PMAX + 50, n);
    chk(n >= PMIN + 30, 1'b1);
    // Timeout routed into the button input
    route_tmo = 1'b1;
    kick();
    wait_sig(1, 1'b0, 1600 * T + 8, n);
    chk(n >= 1599 * T - 12, 1'b1);
    cyc(10);
    chk({lk.reset_n, tmo_seen}, 2'h1);
    cyc(100);
    chk(lk.kick_timeout_n, 1'b0);
    kick();
    chk(lk.kick_timeout_n, 1'b1);
    route_tmo = 1'b0;
    wait_sig(0, 1'b1, PMAX + 80, n);
    // Floating kick line stops the watchdog
    kick();
    float_req = 1'b1;
    cyc(17000);
    chk(lk.kick_timeout_n, 1'b1);
    float_req = 1'b0;
    kick();
    for (int i = 0; i < 4; i++) begin
      aux_mv = aux_tab[i];
      cyc(5);
      chk(lk.aux_fail_n, fail_tab[i]);
    end
    chk(fail_seen, 1'b0);
    route_fail = 1'b1;
    aux_mv = 16'h03e8;
    cyc(10);
    chk({lk.reset_n, in_reset}, 2'h1);
    aux_mv = 16'h07d0;
    route_fail = 1'b0;
    wait_sig(0, 1'b1, PMAX + 80, n);
    test_done();
  end
endmodule : tb_top
